// ==== src/overcurrent_pkg.sv ====
// constants for the over-current detection control block
package overcurrent_pkg;
   // register offsets, chosen for this block
   localparam logic [3:0] MODE_SELECT_ADDR = 4'h0;
   localparam logic [3:0] DAC_CODE_ADDR = 4'h1;
   localparam logic [3:0] OFFSET_TRIM_ADDR = 4'h2;
   localparam logic [3:0] COMP_CTRL_ADDR = 4'h3;
   localparam logic [3:0] IRQ_STATUS_ADDR = 4'h4;
   localparam logic [3:0] IRQ_MASK_ADDR = 4'h5;
   localparam logic [3:0] PROT_STATUS_ADDR = 4'h6;
   // reset values
   localparam logic [7:0] MODE_SELECT_RESET = 8'hC2;
   localparam logic [7:0] DAC_CODE_RESET = 8'h00;
   localparam logic [7:0] OFFSET_TRIM_RESET = 8'h10;
   localparam logic [7:0] COMP_CTRL_RESET = 8'hF0;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   // writable bits
   localparam logic [7:0] MODE_SELECT_MASK = 8'hE7;
   localparam logic [7:0] OFFSET_TRIM_MASK = 8'hDF;
   // field positions
   localparam int EDGE_HI = 7;
   localparam int EDGE_LO = 6;
   localparam int CMP1_SEL_BIT = 5;
   localparam int GAIN_HI = 2;
   localparam int CAL_REF_BIT = 7;
   localparam int CAL_MODE_BIT = 6;
   localparam int TRIM_HI = 4;
   localparam int CMP0_ON_BIT = 0;
   localparam int IRQ_LIMIT_BIT = 0;
   localparam int IRQ_CMP0_BIT = 1;
   // edge codes
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   typedef enum logic [2:0] {
      GAIN_OFF = 3'b000,
      GAIN_X5 = 3'b001,
      GAIN_X10 = 3'b010,
      GAIN_X20 = 3'b011,
      GAIN_X1 = 3'b111
   } gain_t;
endpackage

// ==== src/overcurrent_detect_control.sv ====
// over-current detection control: registers, interrupts and drive cut-off
//
// Notes on behaviour
// - edge field: 00 off incl. DAC, 01 rising, 10 falling, 11 both.
// - dual-edge code still interrupts but never trips the protection.
// - comparator 1 positive input: pin when clear, amplifier output when set.
// - gain 000 off, 001 x5, 010 x10, 011 x20, 111 x1, rest undefined.
// - mode register bits 4 and 3 always read zero.
// - reference DAC runs only while the edge field is nonzero.
// - DAC code is 8-bit read/write, reset zero, linear in 256 steps.
// - calibration reference: inverting input when clear, non-inverting set.
// - amplifier mode bit: normal when clear, offset calibration when set.
// - five-bit trim, 00000 min, 10000 centre, 11111 max, resets centre.
// - calibration register bit 5 always reads zero.
// - two interrupt sources: ADC limit and comparator 0 edges.
// - over-current switches the motor drive outputs off at once.
// - comparator on bit cleared powers it down and holds it inactive.
`timescale 1ns/100ps
module overcurrent_detect_control (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic comparator_zero_out,
   input wire logic adc_limit_event,
   input wire logic [5:0] drive_in,
   output logic [5:0] drive_out,
   output logic comparator_zero_interrupt,
   output logic adc_limit_interrupt,
   output logic irq,
   output logic [7:0] dac_level,
   output logic dac_enable,
   output logic [3:0] comparator_on_bit,
   output logic [3:0] comparator_hysteresis,
   output logic comparator_one_positive_select,
   output logic [2:0] amplifier_gain_field,
   output logic amplifier_enable,
   output logic calibration_reference_select,
   output logic amplifier_calibration_mode,
   output logic [4:0] offset_trim_code
);
   logic [7:0] overcurrent_mode_select;
   logic [7:0] reference_dac_code;
   logic [7:0] amplifier_offset_trim;
   logic [7:0] comparator_control;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic tripped;
   logic cmp_meta;
   logic cmp_sync;
   logic cmp_last;
   logic lim_meta;
   logic lim_sync;
   logic lim_last;
   logic [1:0] edge_field;
   logic cmp_active;
   logic rise;
   logic fall;
   logic cmp_event;
   logic lim_event;
   logic trip_event;
   logic [7:0] next_rdata;

   assign edge_field = overcurrent_mode_select[overcurrent_pkg::EDGE_HI:
                                               overcurrent_pkg::EDGE_LO];
   // comparator counts only when powered and its edge field is nonzero
   assign cmp_active = comparator_control[overcurrent_pkg::CMP0_ON_BIT] &&
                       edge_field != overcurrent_pkg::EDGE_OFF;

   // two flops before any logic reads the analog comparator level
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
         cmp_last <= 1'b0;
         lim_meta <= 1'b0;
         lim_sync <= 1'b0;
         lim_last <= 1'b0;
      end else begin
         cmp_meta <= comparator_zero_out;
         cmp_sync <= cmp_meta;
         // held low while off so power-up is not seen as a falling edge
         cmp_last <= cmp_active ? cmp_sync : 1'b0;
         lim_meta <= adc_limit_event;
         lim_sync <= lim_meta;
         lim_last <= lim_sync;
      end
   end

   assign rise = cmp_active && cmp_sync && !cmp_last;
   assign fall = cmp_active && !cmp_sync && cmp_last &&
                 comparator_control[overcurrent_pkg::CMP0_ON_BIT];
   always_comb begin
      case (edge_field)
         overcurrent_pkg::EDGE_RISE: cmp_event = rise;
         overcurrent_pkg::EDGE_FALL: cmp_event = fall;
         overcurrent_pkg::EDGE_BOTH: cmp_event = rise || fall;
         default: cmp_event = 1'b0;
      endcase
   end
   assign lim_event = lim_sync && !lim_last;
   // comparator edges in dual-edge mode never trip the drive; limit events always do
   assign trip_event = (cmp_event &&
                        edge_field != overcurrent_pkg::EDGE_BOTH) ||
                       lim_event;

   assign comparator_zero_interrupt = cmp_event;
   assign adc_limit_interrupt = lim_event;

   // latched trip; cleared by reading the protection status register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tripped <= 1'b0;
      end else if (trip_event) begin
         tripped <= 1'b1;
      end else if (reg_read &&
                   reg_addr == overcurrent_pkg::PROT_STATUS_ADDR) begin
         tripped <= 1'b0;
      end
   end
   // trip acts combinationally so the drive stops in the same cycle
   assign drive_out = (tripped || trip_event) ? 6'h00 : drive_in;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         overcurrent_mode_select <= overcurrent_pkg::MODE_SELECT_RESET;
      end else if (reg_write &&
                   reg_addr == overcurrent_pkg::MODE_SELECT_ADDR) begin
         overcurrent_mode_select <= reg_wdata &
                                    overcurrent_pkg::MODE_SELECT_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reference_dac_code <= overcurrent_pkg::DAC_CODE_RESET;
      end else if (reg_write &&
                   reg_addr == overcurrent_pkg::DAC_CODE_ADDR) begin
         reference_dac_code <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         amplifier_offset_trim <= overcurrent_pkg::OFFSET_TRIM_RESET;
      end else if (reg_write &&
                   reg_addr == overcurrent_pkg::OFFSET_TRIM_ADDR) begin
         amplifier_offset_trim <= reg_wdata &
                                  overcurrent_pkg::OFFSET_TRIM_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         comparator_control <= overcurrent_pkg::COMP_CTRL_RESET;
      end else if (reg_write &&
                   reg_addr == overcurrent_pkg::COMP_CTRL_ADDR) begin
         comparator_control <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_mask <= overcurrent_pkg::IRQ_MASK_RESET;
      end else if (reg_write &&
                   reg_addr == overcurrent_pkg::IRQ_MASK_ADDR) begin
         irq_mask <= reg_wdata[1:0];
      end
   end

   // sticky status: read clears, but a same-cycle event wins
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_status <= 2'h0;
      end else begin
         if (reg_read && reg_addr == overcurrent_pkg::IRQ_STATUS_ADDR) begin
            irq_status <= {cmp_event, lim_event};
         end else begin
            irq_status <= irq_status | {cmp_event, lim_event};
         end
      end
   end
   assign irq = |(irq_status & irq_mask);

   always_comb begin
      case (reg_addr)
         overcurrent_pkg::MODE_SELECT_ADDR:
            next_rdata = overcurrent_mode_select;
         overcurrent_pkg::DAC_CODE_ADDR: next_rdata = reference_dac_code;
         overcurrent_pkg::OFFSET_TRIM_ADDR:
            next_rdata = amplifier_offset_trim;
         overcurrent_pkg::COMP_CTRL_ADDR: next_rdata = comparator_control;
         overcurrent_pkg::IRQ_STATUS_ADDR: next_rdata = {6'h00, irq_status};
         overcurrent_pkg::IRQ_MASK_ADDR: next_rdata = {6'h00, irq_mask};
         overcurrent_pkg::PROT_STATUS_ADDR:
            next_rdata = {6'h00, cmp_sync, tripped};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // analog controls; DAC code shown as written, gated by its enable
   assign dac_enable = edge_field != overcurrent_pkg::EDGE_OFF;
   assign dac_level = dac_enable ? reference_dac_code : 8'h00;
   assign comparator_on_bit = {comparator_control[3:1], cmp_active};
   assign comparator_hysteresis = comparator_control[7:4];
   assign comparator_one_positive_select =
      overcurrent_mode_select[overcurrent_pkg::CMP1_SEL_BIT];
   assign amplifier_gain_field =
      overcurrent_mode_select[overcurrent_pkg::GAIN_HI:0];
   assign amplifier_enable = amplifier_gain_field !=
                             overcurrent_pkg::GAIN_OFF;
   assign calibration_reference_select =
      amplifier_offset_trim[overcurrent_pkg::CAL_REF_BIT];
   assign amplifier_calibration_mode =
      amplifier_offset_trim[overcurrent_pkg::CAL_MODE_BIT];
   assign offset_trim_code =
      amplifier_offset_trim[overcurrent_pkg::TRIM_HI:0];
endmodule

// ==== sim/overcurrent_detect_control_props.sv ====
// assertion checker for the over-current detection control block
`timescale 1ns/100ps
module overcurrent_detect_props (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic adc_limit_event,
   input wire logic adc_limit_interrupt,
   input wire logic [5:0] drive_in,
   input wire logic [5:0] drive_out,
   input wire logic dac_enable,
   input wire logic [7:0] dac_level,
   input wire logic [3:0] comparator_on_bit,
   input wire logic [2:0] amplifier_gain_field,
   input wire logic amplifier_enable
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_dac_held_off: assert property (!dac_enable |-> !dac_level)
      else $error("dac level while disabled");
   a_cmp0_gated: assert property (
      !dac_enable |-> !comparator_on_bit[0])
      else $error("comparator 0 on with edge field off");
   a_limit_trip: assert property (
      adc_limit_interrupt |-> !drive_out)
      else $error("drive not cut on limit event");
   a_drive_pass: assert property (
      drive_out != 6'h00 |-> drive_out == drive_in)
      else $error("drive altered without trip");
   a_limit_once: assert property (
      adc_limit_interrupt |=> !adc_limit_interrupt)
      else $error("limit pulse too long");
   a_limit_sync: assert property (
      $rose(adc_limit_event) |-> ##[1:4] adc_limit_interrupt)
      else $error("limit event lost");
   a_rdata_idle: assert property (
      !$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_amp_enable: assert property (
      amplifier_enable == (amplifier_gain_field != 3'h0))
      else $error("amplifier enable mismatch");
endmodule

// ==== sim/tb_overcurrent_detect_control.sv ====
// self-checking bench for the over-current detection control block
`timescale 1ns/100ps
module tb_overcurrent_detect_control;
   logic sys_clk = 1'b0, nrst = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, dac_level, v;
   logic comparator_zero_out = 1'b0, adc_limit_event = 1'b0;
   logic [5:0] drive_in = 6'h3F, drive_out;
   logic comparator_zero_interrupt, adc_limit_interrupt, irq, dac_enable;
   logic [3:0] comparator_on_bit, comparator_hysteresis;
   logic comparator_one_positive_select, amplifier_enable;
   logic calibration_reference_select, amplifier_calibration_mode;
   logic [2:0] amplifier_gain_field;
   logic [4:0] offset_trim_code;
   int n_errors = 0, checks_done = 0, pulses = 0;
   logic [7:0] rst_val [6] = '{8'hC2, 8'h00, 8'h10, 8'hF0, 8'h00, 8'h00};
   logic [3:0] rst_adr [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7};
   logic [2:0] gains [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   overcurrent_detect_control DUT (.*);
   always #20 sys_clk = ~sys_clk;
   // pulses of the comparator interrupt are counted as they pass
   always @(posedge sys_clk) if (comparator_zero_interrupt === 1'b1) pulses++;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      // read data stand for one cycle only, so sample just after they land
      #1 check(reg_rdata, exp);
      @(posedge sys_clk);
   endtask
   task automatic settle(input logic cmp, input logic lim);
      comparator_zero_out <= cmp;
      adc_limit_event <= lim;
      // six edges: every pulse has been counted and no new one is due
      repeat (6) @(posedge sys_clk);
   endtask
   task automatic complete_run;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      for (int i = 0; i < 6; i++) rd(rst_adr[i], rst_val[i]);
      wr(4'h7, 8'hFF);
      rd(4'h7, 8'h00);
      wr(overcurrent_pkg::MODE_SELECT_ADDR, 8'hFF);
      rd(overcurrent_pkg::MODE_SELECT_ADDR, 8'hE7);
      wr(overcurrent_pkg::OFFSET_TRIM_ADDR, 8'hFF);
      rd(overcurrent_pkg::OFFSET_TRIM_ADDR, 8'hDF);
      check(8'(calibration_reference_select), 8'h01);
      check(8'(amplifier_calibration_mode), 8'h01);
      wr(overcurrent_pkg::OFFSET_TRIM_ADDR, 8'h00);
      check(8'(offset_trim_code), 8'h00);
      check(8'(calibration_reference_select), 8'h00);
      // pin sharing of the amplifier input is taken as set up here
      foreach (gains[i]) begin
         wr(overcurrent_pkg::MODE_SELECT_ADDR,
            {2'h1, gains[i][0], 2'h0, gains[i]});
         check(8'(amplifier_gain_field), 8'(gains[i]));
         check(8'(amplifier_enable), 8'(gains[i] != 3'h0));
         check(8'(comparator_one_positive_select), 8'(gains[i][0]));
      end
      wr(overcurrent_pkg::MODE_SELECT_ADDR, 8'h02);
      wr(overcurrent_pkg::DAC_CODE_ADDR, 8'hA5);
      check(dac_level, 8'h00);
      check(8'(dac_enable), 8'h00);
      rd(overcurrent_pkg::DAC_CODE_ADDR, 8'hA5);
      wr(overcurrent_pkg::MODE_SELECT_ADDR, 8'h42);
      check(dac_level, 8'hA5);
      check(8'(dac_enable), 8'h01);
      check(8'(comparator_on_bit), 8'h00);
      settle(1'b1, 1'b0);
      settle(1'b0, 1'b0);
      check(8'(pulses), 8'h00);
      wr(overcurrent_pkg::COMP_CTRL_ADDR, 8'hF1);
      check(8'(comparator_hysteresis), 8'h0F);
      check(8'(comparator_on_bit), 8'h01);
      for (int e = 1; e < 4; e++) begin
         wr(overcurrent_pkg::MODE_SELECT_ADDR, {e[1:0], 6'h02});
         pulses = 0;
         settle(1'b1, 1'b0);
         check(8'(pulses), 8'(e[0]));
         check(8'(drive_out), e == 1 ? 8'h00 : 8'h3F);
         settle(1'b0, 1'b0);
         check(8'(pulses), e == 3 ? 8'h02 : 8'h01);
         rd(overcurrent_pkg::PROT_STATUS_ADDR, 8'(e != 3));
      end
      wr(overcurrent_pkg::IRQ_MASK_ADDR, 8'h03);
      rd(overcurrent_pkg::IRQ_STATUS_ADDR, 8'h02);
      settle(1'b0, 1'b1);
      check(8'(irq), 8'h01);
      check(8'(drive_out), 8'h00);
      rd(overcurrent_pkg::IRQ_STATUS_ADDR, 8'h01);
      check(8'(irq), 8'h00);
      rd(overcurrent_pkg::PROT_STATUS_ADDR, 8'h01);
      check(8'(drive_out), 8'h3F);
      wr(overcurrent_pkg::IRQ_MASK_ADDR, 8'h00);
      settle(1'b0, 1'b0);
      settle(1'b0, 1'b1);
      check(8'(irq), 8'h00);
      rd(overcurrent_pkg::IRQ_STATUS_ADDR, 8'h01);
      complete_run();
   end
   initial begin
      repeat (3000) @(posedge sys_clk);
      n_errors++;
      complete_run();
   end
endmodule
bind overcurrent_detect_control overcurrent_detect_props u_props (.*);
